/* shared/iwc_pkg.sv */
// iwc_pkg: constants for the input tri-state and wetting level registers
// assumes a 100 MHz system clock; spi frames are 32 bits, msb first
package iwc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_BITS = 32;
    localparam int ADDR_W     = 7;
    localparam int ADDR_MSB   = 31;
    localparam int ADDR_LSB   = 25;
    localparam int RW_BIT     = 24;
    localparam int DATA_W     = 24;
    localparam int CNT_W      = 6;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [6:0] ADDR_GND_HIGHZ   = 7'h03;
    localparam logic [6:0] ADDR_PROG_LVL_LO = 7'h04;
    localparam logic [6:0] ADDR_GND_LVL_LO  = 7'h05;
    localparam logic [6:0] ADDR_PROG_LVL_HI = 7'h08;

    ////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int GND_CH       = 21;
    localparam int PROG_CH      = 12;
    localparam int LVL_W        = 3;
    localparam int LVL_LO_CH    = 8;
    localparam int PROG_HI_CH   = 4;
    localparam int FAULT_BIT    = 23;
    localparam int INTF_BIT     = 22;
    localparam int FLAG_DATA_W  = 22;

    ////////////////////////////////////////////////////////////////////////////
    // reset values: all inputs high impedance, level code for 16 mA
    localparam logic [2:0]  LVL_16MA        = 3'h6;
    localparam logic [20:0] HIGHZ_RESET     = 21'h1fffff;
    localparam logic [23:0] LVL_LO_RESET    = {8{LVL_16MA}};
    localparam logic [11:0] PROG_HI_RESET   = {4{LVL_16MA}};

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int ACTIVE_POLL_NS = 55000;
    localparam int ACTIVE_POLL_CYC = (ACTIVE_POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : iwc_pkg

/* design/iwc_spi_link.sv */
// iwc_spi_link: spi slave that samples the link pins with the system clock
// assumes sclk at most clk/8; mode 0 style: mosi taken on rising sclk,
// miso moved on falling sclk, frames framed by active low chip select
`timescale 1ns/10ps
module iwc_spi_link
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // link pins
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    // frame side
    input  wire logic [31:0] resp_i,
    output logic             frame_vld_o,
    output logic [31:0]      frame_o
);

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers plus one history stage for edge detection
    logic [2:0]  sclk_q;
    logic [2:0]  cs_q;
    logic [1:0]  mosi_q;
    logic [31:0] rx_q;
    logic [31:0] tx_q;
    logic [5:0]  cnt_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sclk_q <= 3'h0;
            cs_q   <= 3'h7;
            mosi_q <= 2'h0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            cs_q   <= {cs_q[1:0], cs_n_i};
            mosi_q <= {mosi_q[0], mosi_i};
        end
    end

    // only stages 1 and 2 are looked at, never the first flop
    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign cs_fall   = ~cs_q[1] & cs_q[2];
    assign cs_rise   = cs_q[1] & ~cs_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // shift in on rising sclk, count bits of the frame
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_q  <= 32'h0;
            cnt_q <= 6'h0;
        end
        else if (cs_fall)
        begin
            cnt_q <= 6'h0;
        end
        else if (!cs_q[2] && sclk_rise)
        begin
            rx_q  <= {rx_q[30:0], mosi_q[1]};
            cnt_q <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer word loaded at select, msb first, advanced on falling sclk
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tx_q <= 32'h0;
        else if (cs_fall)
            tx_q <= resp_i;
        else if (!cs_q[2] && sclk_fall)
            tx_q <= {tx_q[30:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame strobe: wrong bit counts are dropped so a glitch cannot write
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            frame_vld_o <= 1'b0;
            frame_o     <= 32'h0;
            miso_o      <= 1'b0;
            miso_oe_o   <= 1'b0;
        end
        else
        begin
            frame_vld_o <= cs_rise && (cnt_q == 6'(iwc_pkg::FRAME_BITS));
            if (cs_rise)
                frame_o <= rx_q;
            miso_o    <= (cs_fall) ? resp_i[31] : tx_q[31];
            miso_oe_o <= ~cs_q[1];
        end
    end

endmodule : iwc_spi_link

/* design/iwc_poll_stage.sv */
// iwc_poll_stage: one active poll window over the ground inputs
// assumes poll_start_i comes from the polling scheduler on this clock and
// comparator outputs arrive asynchronously from the analog front end
`timescale 1ns/10ps
module iwc_poll_stage
#(
    parameter int CH      = 21,
    parameter int ACT_CYC = 5500
)
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // control
    input  wire logic          poll_start_i,
    input  wire logic          lpm_i,
    input  wire logic [CH-1:0] highz_i,
    input  wire logic [CH-1:0] cmp_i,
    // results
    output logic [CH-1:0]      current_en_o,
    output logic [CH-1:0]      cmp_en_o,
    output logic [CH-1:0]      change_o,
    output logic               wake_o
);

    localparam int CW = $clog2(ACT_CYC + 1);

    logic [CH-1:0] cmp_s1_q;
    logic [CH-1:0] cmp_s2_q;
    logic [CH-1:0] last_q;
    logic [CW-1:0] cnt_q;
    logic          busy_q;
    logic          busy_d;
    logic          end_d;

    ////////////////////////////////////////////////////////////////////////////
    // comparator synchroniser
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmp_s1_q <= '0;
            cmp_s2_q <= '0;
        end
        else
        begin
            cmp_s1_q <= cmp_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active poll window timer; a start during a window is ignored
    assign end_d  = busy_q && (cnt_q == '0);
    assign busy_d = (busy_q && !end_d) || (!busy_q && poll_start_i);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end
        else
        begin
            busy_q <= busy_d;
            if (!busy_q && poll_start_i)
                cnt_q <= CW'(ACT_CYC - 1);
            else if (busy_q && !end_d)
                cnt_q <= cnt_q - CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sources follow the window but a tri-stated input never gets one,
    // in normal mode and in low power mode alike; comparators stay on
    // highz blocks source
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            current_en_o <= '0;
            cmp_en_o     <= '0;
        end
        else
        begin
            current_en_o <= {CH{busy_d}} & ~highz_i;
            cmp_en_o     <= {CH{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decide at window end
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            last_q   <= '0;
            change_o <= '0;
            wake_o   <= 1'b0;
        end
        else
        begin
            change_o <= end_d ? (cmp_s2_q ^ last_q) : '0;
            wake_o   <= end_d && lpm_i && (|(cmp_s2_q ^ last_q));
            if (end_d)
                last_q <= cmp_s2_q;
        end
    end

endmodule : iwc_poll_stage

/* design/iwc_cfg_regs.sv */
// iwc_cfg_regs: ground-input tri-state and wetting level registers
// assumes a host spi master on the link pins and flag events from the
// fault and interrupt logic on the system clock
`timescale 1ns/10ps

// How it works
// - 32-bit frame: address, rw, data
// - ground tri-state register at address three
// - tri-stated input never gets current source
// - comparator of tri-stated input stays on
// - tri-state writes take effect at once
// - all tri-state bits reset to one
// - low power polls tri-stated without source
// - change and wake decided at window end
// - one three-bit level field per channel
// - level fields reset to 16 mA code
// - programmable level low at address four
// - programmable level high at eight, flags
// - ground level low at address five
// - ground level writes take effect at once, programmable levels one cycle later
// - code maps to current level
// - fault flag set, cleared by clean read
// - interrupt flag cleared by any access to address three or eight
module iwc_cfg_regs
#(
    parameter int ACTIVE_POLL_CYC = iwc_pkg::ACTIVE_POLL_CYC
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // spi link
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    // global flag events
    input  wire logic        fault_event_i,
    input  wire logic        fault_present_i,
    input  wire logic        fault_status_read_i,
    input  wire logic        int_event_i,
    // polling control
    input  wire logic        low_power_mode_i,
    input  wire logic        poll_start_i,
    input  wire logic [20:0] gnd_cmp_i,
    // channel configuration
    output logic [20:0]      gnd_highz_o,
    output logic [35:0]      prog_level_o,
    output logic [23:0]      gnd_level_o,
    // polling results
    output logic [20:0]      gnd_current_en_o,
    output logic [20:0]      gnd_cmp_en_o,
    output logic [20:0]      gnd_change_o,
    output logic             wake_o,
    // flags
    output logic             fault_flag_o,
    output logic             int_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // frame fields
    logic        frame_vld;
    logic [31:0] frame;
    logic [6:0]  fr_addr;
    logic        fr_wr;
    logic [23:0] fr_data;
    logic [31:0] resp_q;
    logic [23:0] sp_lo_q;
    logic [11:0] sp_hi_q;
    logic        flag_acc;

    assign fr_addr = frame[iwc_pkg::ADDR_MSB:iwc_pkg::ADDR_LSB];
    assign fr_wr   = frame[iwc_pkg::RW_BIT];
    assign fr_data = frame[iwc_pkg::DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // link front end
    iwc_spi_link u_link
    (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .sclk_i      (sclk_i),
        .cs_n_i      (cs_n_i),
        .mosi_i      (mosi_i),
        .miso_o      (miso_o),
        .miso_oe_o   (miso_oe_o),
        .resp_i      (resp_q),
        .frame_vld_o (frame_vld),
        .frame_o     (frame)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read word of an address; flag registers carry the two global flags
    // unused bits read zero
    function automatic logic [23:0] rd_word(input logic [6:0] a);
        logic [23:0] w;
        w = 24'h0;
        unique case (a)
            iwc_pkg::ADDR_GND_HIGHZ:
                w = {fault_flag_o, int_flag_o, 1'b0, gnd_highz_o};
            iwc_pkg::ADDR_PROG_LVL_LO:
                w = sp_lo_q;
            iwc_pkg::ADDR_GND_LVL_LO:
                w = gnd_level_o;
            iwc_pkg::ADDR_PROG_LVL_HI:
                w = {fault_flag_o, int_flag_o, 10'h0, sp_hi_q};
            default:
                w = 24'h0;
        endcase
        return w;
    endfunction : rd_word

    // true for registers that hold the interrupt flag
    function automatic logic has_flags(input logic [6:0] a);
        return (a == iwc_pkg::ADDR_GND_HIGHZ) || (a == iwc_pkg::ADDR_PROG_LVL_HI);
    endfunction : has_flags

    assign flag_acc = frame_vld && has_flags(fr_addr);

    ////////////////////////////////////////////////////////////////////////////
    // answer for the next frame: echoed address and rw plus read data,
    // captured before the flags clear so the host sees what caused them
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            resp_q <= 32'h0;
        else if (frame_vld)
            resp_q <= {fr_addr, fr_wr, rd_word(fr_addr)};
    end

    ////////////////////////////////////////////////////////////////////////////
    // ground tri-state register, one bit per ground input
    // tri-state register write
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            gnd_highz_o <= iwc_pkg::HIGHZ_RESET;
        else if (frame_vld && fr_wr && fr_addr == iwc_pkg::ADDR_GND_HIGHZ)
            gnd_highz_o <= fr_data[iwc_pkg::GND_CH-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // level registers; bits 2:0 channel 0 upward, code 3'h6 is 16 mA, the
    // code is passed to the current dac unchanged (000 2 mA .. 111 20 mA)
    // three bits per channel
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sp_lo_q     <= iwc_pkg::LVL_LO_RESET;
            gnd_level_o <= iwc_pkg::LVL_LO_RESET;
        end
        else if (frame_vld && fr_wr)
        begin
            if (fr_addr == iwc_pkg::ADDR_PROG_LVL_LO)
                sp_lo_q <= fr_data;
            if (fr_addr == iwc_pkg::ADDR_GND_LVL_LO)
                gnd_level_o <= fr_data;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sp_hi_q <= iwc_pkg::PROG_HI_RESET;
        else if (frame_vld && fr_wr && fr_addr == iwc_pkg::ADDR_PROG_LVL_HI)
            sp_hi_q <= fr_data[iwc_pkg::PROG_HI_CH*iwc_pkg::LVL_W-1:0];
    end

    // drive the twelve programmable levels from one flop stage
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prog_level_o <= {iwc_pkg::PROG_HI_RESET, iwc_pkg::LVL_LO_RESET};
        else
            prog_level_o <= {sp_hi_q, sp_lo_q};
    end

    ////////////////////////////////////////////////////////////////////////////
    // global flags; a new event in the clearing cycle keeps the flag set
    // fault flag set wins
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fault_flag_o <= 1'b0;
        else if (fault_event_i)
            fault_flag_o <= 1'b1;
        else if (fault_status_read_i && !fault_present_i)
            fault_flag_o <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            int_flag_o <= 1'b0;
        else if (int_event_i)
            int_flag_o <= 1'b1;
        else if (flag_acc)
            int_flag_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // poll window and source gating
    // comparators kept enabled
    iwc_poll_stage
    #(
        .CH      (iwc_pkg::GND_CH),
        .ACT_CYC (ACTIVE_POLL_CYC)
    )
    u_poll
    (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .poll_start_i (poll_start_i),
        .lpm_i        (low_power_mode_i),
        .highz_i      (gnd_highz_o),
        .cmp_i        (gnd_cmp_i),
        .current_en_o (gnd_current_en_o),
        .cmp_en_o     (gnd_cmp_en_o),
        .change_o     (gnd_change_o),
        .wake_o       (wake_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic up_q;

    // marks the cycles after the first one out of reset
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            up_q <= 1'b0;
        else
            up_q <= 1'b1;
    end

    a_reset_defaults:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        !up_q |-> gnd_highz_o == iwc_pkg::HIGHZ_RESET
                  && gnd_level_o == iwc_pkg::LVL_LO_RESET)
    else $error("registers not at defaults after reset");

    a_level_reset:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        !up_q |-> ##1 prog_level_o == {iwc_pkg::PROG_HI_RESET, iwc_pkg::LVL_LO_RESET})
    else $error("programmable levels not 16 mA after reset");

    a_highz_write:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && fr_wr && fr_addr == iwc_pkg::ADDR_GND_HIGHZ
        |=> gnd_highz_o == $past(fr_data[20:0]))
    else $error("tri-state write not applied");

    a_level_write:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && fr_wr && fr_addr == iwc_pkg::ADDR_PROG_LVL_LO
        |=> ##1 prog_level_o[23:0] == $past(fr_data, 2))
    else $error("level write not applied");

    a_read_no_change:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && !fr_wr |=> $stable(gnd_highz_o) && $stable(gnd_level_o)
                                && $stable(sp_lo_q) && $stable(sp_hi_q))
    else $error("read changed a register");

    a_hi_unused_zero:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && fr_addr == iwc_pkg::ADDR_PROG_LVL_HI
        |=> resp_q[21:12] == 10'h0 && resp_q[23] == $past(fault_flag_o))
    else $error("unused bits or flag wrong in answer");

    a_int_clear:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        flag_acc && !int_event_i |=> !int_flag_o)
    else $error("interrupt flag not cleared by access");

    a_int_set_wins:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        int_event_i |=> int_flag_o)
    else $error("interrupt event lost");

    a_fault_clear:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        fault_flag_o && !fault_event_i && !(fault_status_read_i && !fault_present_i)
        |=> fault_flag_o)
    else $error("fault flag dropped without clean read");

    a_highz_source:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        up_q |-> (gnd_current_en_o & $past(gnd_highz_o)) == 21'h0)
    else $error("source on for a tri-stated input");

    a_wake_lpm:
    assert property (@(posedge clk_i) disable iff (!nrst_i)
        wake_o |-> $past(low_power_mode_i) && gnd_change_o != 21'h0)
    else $error("wake without change in low power mode");

    c_highz_write:
    cover property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && fr_wr && fr_addr == iwc_pkg::ADDR_GND_HIGHZ);

    c_level_read:
    cover property (@(posedge clk_i) disable iff (!nrst_i)
        frame_vld && !fr_wr && fr_addr == iwc_pkg::ADDR_GND_LVL_LO);

    c_int_race:
    cover property (@(posedge clk_i) disable iff (!nrst_i)
        flag_acc && int_event_i);

    c_wake:
    cover property (@(posedge clk_i) disable iff (!nrst_i) wake_o);

endmodule : iwc_cfg_regs

/* dv/iwc_spi_host.sv */
// iwc_spi_host: spi master model standing in for the host controller
// assumes the bench calls xfer only after reset; sclk idles low outside frames
`timescale 1ns/10ps
module iwc_spi_host
(
    // clock
    input  wire logic clk_i,
    // link pins
    input  wire logic miso_i,
    input  wire logic miso_oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    ////////////////////////////////////////////////////////////////////////////
    // every change lands just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    ////////////////////////////////////////////////////////////////////////////
    // one frame msb first; half sets the speed, so prompt and slow hosts both exist
    // word is address, rw, data; the answer is sampled on rising sclk
    task automatic xfer(input logic [31:0] w, input int half, output logic [31:0] r);
        cs_n_o = 1'b0;
        tick(4);
        for (int i = 31; i >= 0; i--)
        begin
            mosi_o = w[i];
            tick(half);
            sclk_o = 1'b1;
            // an undriven line reads as the inverse, so a missing enable shows up
            r[i] = miso_oe_i ? miso_i : ~miso_i;
            tick(half);
            sclk_o = 1'b0;
        end
        tick(4);
        cs_n_o = 1'b1;
        // released line shows the inverse so a stale bit never looks right
        mosi_o = ~mosi_o;
        tick(8);
    endtask : xfer

    // idle pins at time zero
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
endmodule : iwc_spi_host

/* dv/input_tristate_wetting_cfg_regs_bench.sv */
// input_tristate_wetting_cfg_regs_bench: self-checking bench of the config registers
// assumes the host model owns the link pins; answers arrive one frame late
`timescale 1ns/10ps
module input_tristate_wetting_cfg_regs_bench;
    logic        clk_i, nrst_i, sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_o;
    logic        fault_event_i, fault_present_i, fault_status_read_i, int_event_i;
    logic        low_power_mode_i, poll_start_i, wake_o, fault_flag_o, int_flag_o;
    logic [20:0] gnd_cmp_i, gnd_highz_o, gnd_current_en_o, gnd_cmp_en_o, gnd_change_o;
    logic [35:0] prog_level_o;
    logic [23:0] gnd_level_o;
    logic [31:0] ans;
    int          num_errors = 0;
    int          n_checks   = 0;

    // short poll window keeps the run brief
    iwc_cfg_regs #(.ACTIVE_POLL_CYC(20)) dut
    (
        .clk_i, .nrst_i, .sclk_i, .cs_n_i, .mosi_i, .miso_o, .miso_oe_o,
        .fault_event_i, .fault_present_i, .fault_status_read_i, .int_event_i,
        .low_power_mode_i, .poll_start_i, .gnd_cmp_i, .gnd_highz_o, .prog_level_o,
        .gnd_level_o, .gnd_current_en_o, .gnd_cmp_en_o, .gnd_change_o, .wake_o,
        .fault_flag_o, .int_flag_o
    );
    iwc_spi_host host
    (
        .clk_i, .miso_i(miso_o), .miso_oe_i(miso_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
        .mosi_o(mosi_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // the read answer rides on a following harmless frame
    task automatic rd(input logic [6:0] a, output logic [23:0] d);
        host.xfer({a, 1'b0, 24'h0}, 8, ans);
        host.xfer({7'h05, 1'b0, 24'h0}, 4, ans);
        d = ans[23:0];
        chk("echo", ans[31:24], {a, 1'b0});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [23:0] d;
        chk("highz", gnd_highz_o, 21'h1fffff);
        chk("gnd_lvl", gnd_level_o, 24'hdb6db6);
        chk("prog_lvl", prog_level_o, 36'hdb6db6db6);
        chk("oe_idle", miso_oe_o, 1'b0);
        rd(7'h03, d);
        chk("rd_highz", d, 24'h1fffff);
    endtask : t_reset

    // flag and unused bits written as ones must not stick
    task automatic t_write();
        logic [6:0]  a [4] = '{7'h03, 7'h04, 7'h05, 7'h08};
        logic [23:0] w [4] = '{24'hf5a5a5, 24'h2c688f, 24'h053977, 24'hffffff};
        logic [23:0] e [4] = '{24'h15a5a5, 24'h2c688f, 24'h053977, 24'h000fff};
        logic [23:0] d;
        for (int i = 0; i < 4; i++)
        begin
            host.xfer({a[i], 1'b1, w[i]}, 8, ans);
            rd(a[i], d);
            chk("readback", d, e[i]);
        end
        chk("highz", gnd_highz_o, 21'h15a5a5);
        chk("prog_lvl", prog_level_o, 36'hfff2c688f);
        chk("gnd_lvl", gnd_level_o, 24'h053977);
        rd(7'h09, d);
        chk("unmapped", d, 24'h0);
    endtask : t_write

    task automatic t_flags();
        logic [23:0] d;
        int_event_i = 1'b1;
        fault_event_i = 1'b1;
        step(1);
        int_event_i = 1'b0;
        fault_event_i = 1'b0;
        fault_present_i = 1'b1;
        step(1);
        chk("int_set", int_flag_o, 1'b1);
        rd(7'h08, d);
        chk("rd_flags", d[23:22], 2'h3);
        chk("int_clr", int_flag_o, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            fault_status_read_i = 1'b1;
            step(1);
            fault_status_read_i = 1'b0;
            step(1);
            chk("fault", fault_flag_o, i == 0);
            fault_present_i = 1'b0;
        end
    endtask : t_flags

    // inputs 0..3 tri-stated, inputs 0 and 1 changed, low power on
    task automatic t_poll();
        int n = 0;
        host.xfer({7'h03, 1'b1, 24'h00000f}, 8, ans);
        low_power_mode_i = 1'b1;
        gnd_cmp_i = 21'h000003;
        step(4);
        poll_start_i = 1'b1;
        step(1);
        poll_start_i = 1'b0;
        step(3);
        chk("cur_en", gnd_current_en_o, 21'h1ffff0);
        chk("cmp_en", gnd_cmp_en_o, 21'h1fffff);
        while (wake_o !== 1'b1 && n < 60)
        begin
            step(1);
            n++;
        end
        chk("change", gnd_change_o, 21'h000003);
        chk("window", n >= 16, 1'b1);
        step(1);
        chk("wake_pulse", wake_o, 1'b0);
        // normal mode: the change is still reported, but nothing wakes
        low_power_mode_i = 1'b0;
        gnd_cmp_i = 21'h000000;
        poll_start_i = 1'b1;
        step(1);
        poll_start_i = 1'b0;
        n = 0;
        while (gnd_change_o === 21'h0 && n < 60)
        begin
            step(1);
            n++;
        end
        chk("change_nrm", gnd_change_o, 21'h000003);
        chk("no_wake", wake_o, 1'b0);
    endtask : t_poll

    ////////////////////////////////////////////////////////////////////////////
    // verdict, watchdog, clock and main sequence
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // about twenty frames of five microseconds each, so one millisecond is ample
    initial
    begin
        #1_000_000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        {nrst_i, fault_event_i, fault_present_i, fault_status_read_i} = 4'h0;
        {int_event_i, low_power_mode_i, poll_start_i} = 3'h0;
        gnd_cmp_i = 21'h0;
        repeat (6) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        step(4);
        t_reset();
        t_write();
        t_flags();
        t_poll();
        complete_run();
    end
endmodule : input_tristate_wetting_cfg_regs_bench
